// >>> dtl_pkg.sv
// Shared constants and types of the loop tuning and lock detect block
package dtl_pkg;

    // Clock and lock timer unit
    localparam int CLK_HZ = 50_000_000;
    localparam int LOCK_UNIT_MS = 1;
    localparam int CYCLES_PER_MS = (CLK_HZ / 1000) * LOCK_UNIT_MS;

    // Register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_FB_CORR = 8'h00;
    localparam logic [7:0] OFS_PHASE = 8'h04;
    localparam logic [7:0] OFS_FCW = 8'h08;
    localparam logic [7:0] OFS_LOCK = 8'h0C;
    localparam logic [7:0] OFS_TDC_DLY = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_EVENT = 8'h18;
    localparam logic [7:0] OFS_MASK = 8'h1C;
    localparam logic [7:0] OFS_CTRL = 8'h20;

    // Feedback correction fields
    localparam int FC_W = 10;
    localparam int FC_REV_BIT = 9;
    localparam int FC_DLY_HI = 8;
    localparam int FC_DLY_LO = 7;
    localparam int FC_MULT_HI = 6;
    localparam logic [1:0] FC_DLY_ONE = 2'h1;
    localparam logic [9:0] RST_FB_CORR = 10'h000;

    // Phase shift and frequency word fields
    localparam int PHS_W = 30;
    localparam int FCW_W = 29;
    localparam int MSB_LANE = 3;
    localparam logic [31:0] RST_PHASE = 32'h0000_0000;
    localparam logic [31:0] RST_FCW = 32'h0000_0000;

    // Lock control fields
    localparam int LK_TIMER_LSB = 16;
    localparam logic [15:0] RST_LOCK_TIMER = 16'h00FF;
    localparam logic [15:0] RST_LOCK_THRESH = 16'h0155;
    localparam int THR_SCALE_SH = 3;

    // Digitizer delay
    localparam logic [7:0] RST_TDC_DLY = 8'h1F;

    // Event bits
    localparam int EV_W = 3;
    localparam int EV_LOL = 0;
    localparam int EV_STATE_CH = 1;
    localparam int EV_LOCKED = 2;

    // Control bits
    localparam int CTRL_PROFILE_SW = 0;

    // Status state codes
    localparam int ST_CODE_LSB = 4;
    localparam logic [2:0] ST_CODE_NORMAL = 3'h1;
    localparam logic [2:0] ST_CODE_ACQUIRE = 3'h4;

    typedef enum logic [2:0] {
        LS_ACQ = 3'b001,
        LS_NORM = 3'b010,
        LS_LOCK = 3'b100
    } dtl_lock_state_t;

endpackage

// >>> dtl_lock_if.sv
// Signals between the register bank and the lock qualifier
`timescale 1ns/1ps
interface dtl_lock_if;
    import dtl_pkg::*;
    logic ms_tick;
    logic run;
    logic err_below;
    logic [15:0] half_ms;
    dtl_lock_state_t state;
    logic to_normal;
    logic gained;
    logic lol;
    logic locked;

    modport ctl (
        output ms_tick, run, err_below, half_ms,
        input state, to_normal, gained, lol, locked
    );
    modport det (
        input ms_tick, run, err_below, half_ms,
        output state, to_normal, gained, lol, locked
    );
endinterface

// >>> dtl_lock_det.sv
// Lock qualifier: acquire, normal and locked states over timed intervals
`timescale 1ns/1ps
module dtl_lock_det
    import dtl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to register bank
    dtl_lock_if.det lk
);

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic half_done;

    assign cnt_nxt = cnt_r + 16'h0001;
    assign half_done = (cnt_nxt >= lk.half_ms);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk.state <= LS_ACQ;
            cnt_r <= 16'h0000;
            lk.to_normal <= 1'b0;
            lk.gained <= 1'b0;
            lk.lol <= 1'b0;
        end else begin
            lk.to_normal <= 1'b0;
            lk.gained <= 1'b0;
            lk.lol <= 1'b0;
            if (!lk.run) begin
                lk.state <= LS_ACQ;
                cnt_r <= 16'h0000;
                lk.lol <= (lk.state == LS_LOCK);
            end else begin
                case (lk.state)
                    LS_ACQ: begin
                        if (!lk.err_below) begin
                            cnt_r <= 16'h0000;
                        end else if (lk.ms_tick) begin
                            if (half_done) begin
                                lk.state <= LS_NORM;
                                lk.to_normal <= 1'b1;
                                cnt_r <= 16'h0000;
                            end else begin
                                cnt_r <= cnt_nxt;
                            end
                        end
                    end
                    LS_NORM: begin
                        if (!lk.err_below) begin
                            cnt_r <= 16'h0000;
                        end else if (lk.ms_tick) begin
                            if (half_done) begin
                                lk.state <= LS_LOCK;
                                lk.gained <= 1'b1;
                                cnt_r <= 16'h0000;
                            end else begin
                                cnt_r <= cnt_nxt;
                            end
                        end
                    end
                    LS_LOCK: begin
                        // Losing the threshold drops lock and requalifies
                        if (!lk.err_below) begin
                            lk.state <= LS_ACQ;
                            lk.lol <= 1'b1;
                            cnt_r <= 16'h0000;
                        end
                    end
                    default: begin
                        lk.state <= LS_ACQ;
                        cnt_r <= 16'h0000;
                    end
                endcase
            end
        end
    end

    assign lk.locked = (lk.state == LS_LOCK);

endmodule // dtl_lock_det

// >>> dtl_ms_tick.sv
// Divider that gives a one-cycle pulse each millisecond
`timescale 1ns/1ps
module dtl_ms_tick #(
    parameter int DIV = 50000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Tick out
    output logic tick
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_r == LAST);
            if (cnt_r == LAST) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + CW'(1);
            end
        end
    end

endmodule // dtl_ms_tick

// >>> dtl_regs.sv
// Loop tuning and lock detect register bank with APB slave
//
// Overview of operation
// - Timestamp lines pass straight when reversal bit is 0, reversed when 1.
// - Delay field 0x1 delays the sigma-delta error one cycle; others none.
// - Manual phase shift is a 30-bit two's complement value for all outputs.
// - Manual phase shift is ignored while hitless reference switching is on.
// - Phase shift bytes are held until the top byte is written.
// - Frequency word is a 29-bit two's complement value of fine ppm units.
// - Frequency word takes effect only when its top byte is written.
// - Acquire goes to normal after half the interval below threshold.
// - With profile switching on, filter takes normal settings then.
// - Normal declares lock after a further half interval below threshold.
// - The eight-bit digitizer delay setting, default 0x1F, goes to the loop.
// - Losing lock sets a sticky loss-of-lock flag, cleared by writing one or by reading it.
`timescale 1ns/1ps
module dtl_regs
    import dtl_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS,
    parameter int SDM_W = 16,
    parameter int ERR_W = 24
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Loop inputs
    input wire logic [30:0] fine_ts_in,
    input wire logic [SDM_W-1:0] sdm_err_in,
    input wire logic [ERR_W-1:0] phase_err_in,
    input wire logic hitless_en,
    input wire logic loop_run,
    // Loop outputs
    output logic [30:0] fine_ts_out,
    output logic [SDM_W-1:0] sdm_err_out,
    output logic [6:0] corr_mult_out,
    output logic [PHS_W-1:0] phase_shift_out,
    output logic [FCW_W-1:0] fcw_out,
    output logic fcw_load,
    output logic [7:0] tdc_delay_out,
    output logic filter_normal_sel,
    output logic lock_out,
    // Interrupt
    output logic irq
);

    dtl_lock_if lk ();

    logic [FC_W-1:0] fb_corr_r;
    logic [31:0] phs_stage_r;
    logic [PHS_W-1:0] phs_act_r;
    logic [31:0] fcw_stage_r;
    logic [FCW_W-1:0] fcw_act_r;
    logic fcw_upd_r;
    logic [31:0] lock_ctl_r;
    logic [7:0] tdc_dly_r;
    logic [0:0] ctrl_r;
    logic [EV_W-1:0] ev_r;
    logic [EV_W-1:0] ev_nxt;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [EV_W-1:0] mask_r;
    logic [SDM_W-1:0] sdm_d_r;
    logic err_below_r;
    logic [ERR_W-1:0] abs_err;
    logic [ERR_W+THR_SCALE_SH:0] thr_scaled;
    logic [30:0] fine_rev;
    logic access;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic [2:0] st_code;

    // Byte-lane merge, shared by the writable registers except control, mask and event
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_addr(
        input logic [ADDR_W-1:0] a,
        input logic [7:0] ofs
    );
        return (a == ofs);
    endfunction

    // One wait state keeps prdata and pslverr straight from flops
    assign access = psel & penable;
    assign wr_en = access & pready & pwrite;
    assign rd_en = access & pready & ~pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access & ~pready;
        end
    end

    // Read decode
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            OFS_FB_CORR: rd_mux = {22'h000000, fb_corr_r};
            OFS_PHASE: rd_mux = phs_stage_r;
            OFS_FCW: rd_mux = fcw_stage_r;
            OFS_LOCK: rd_mux = lock_ctl_r;
            OFS_TDC_DLY: rd_mux = {24'h000000, tdc_dly_r};
            OFS_STATUS: rd_mux = {25'h0000000, st_code, 3'h0, lk.locked};
            OFS_EVENT: rd_mux = {29'h00000000, ev_r};
            OFS_MASK: rd_mux = {29'h00000000, mask_r};
            OFS_CTRL: rd_mux = {31'h00000000, ctrl_r};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~rd_hit;
        end
    end

    // Feedback correction configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_corr_r <= RST_FB_CORR;
        end else if (wr_en && is_addr(paddr, OFS_FB_CORR)) begin
            fb_corr_r <= FC_W'(merge({22'h000000, fb_corr_r}, pwdata, pstrb));
        end
    end

    // Phase shift: staging shows partial bytes, active copy waits for top lane
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phs_stage_r <= RST_PHASE;
            phs_act_r <= PHS_W'(RST_PHASE);
        end else if (wr_en && is_addr(paddr, OFS_PHASE)) begin
            phs_stage_r <= {2'h0, PHS_W'(merge(phs_stage_r, pwdata, pstrb))};
            if (pstrb[MSB_LANE]) begin
                phs_act_r <= PHS_W'(merge(phs_stage_r, pwdata, pstrb));
            end
        end
    end

    // Frequency word follows the same atomic scheme
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcw_stage_r <= RST_FCW;
            fcw_act_r <= FCW_W'(RST_FCW);
            fcw_upd_r <= 1'b0;
        end else begin
            fcw_upd_r <= 1'b0;
            if (wr_en && is_addr(paddr, OFS_FCW)) begin
                fcw_stage_r <= {3'h0,
                                FCW_W'(merge(fcw_stage_r, pwdata, pstrb))};
                if (pstrb[MSB_LANE]) begin
                    fcw_act_r <= FCW_W'(merge(fcw_stage_r, pwdata,
                                              pstrb));
                    fcw_upd_r <= 1'b1;
                end
            end
        end
    end

    // Lock timer and threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ctl_r <= {RST_LOCK_TIMER, RST_LOCK_THRESH};
        end else if (wr_en && is_addr(paddr, OFS_LOCK)) begin
            lock_ctl_r <= merge(lock_ctl_r, pwdata, pstrb);
        end
    end

    // Digitizer delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdc_dly_r <= RST_TDC_DLY;
        end else if (wr_en && is_addr(paddr, OFS_TDC_DLY)) begin
            tdc_dly_r <= 8'(merge({24'h000000, tdc_dly_r}, pwdata, pstrb));
        end
    end

    // Control and interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 1'b0;
            mask_r <= '0;
        end else if (wr_en) begin
            if (is_addr(paddr, OFS_CTRL) && pstrb[0]) begin
                ctrl_r <= pwdata[CTRL_PROFILE_SW];
            end
            if (is_addr(paddr, OFS_MASK) && pstrb[0]) begin
                mask_r <= pwdata[EV_W-1:0];
            end
        end
    end

    // Sticky events; a new event in the clearing cycle survives
    assign ev_set[EV_LOL] = lk.lol;
    assign ev_set[EV_STATE_CH] = lk.to_normal | lk.gained | lk.lol;
    assign ev_set[EV_LOCKED] = lk.gained;

    always_comb begin
        ev_clr = '0;
        if (wr_en && is_addr(paddr, OFS_EVENT) && pstrb[0]) begin
            ev_clr = pwdata[EV_W-1:0];
        end
        if (rd_en && is_addr(paddr, OFS_EVENT)) begin
            // Clear only what the read returned; a later event is kept
            ev_clr = prdata[EV_W-1:0];
        end
        ev_nxt = (ev_r & ~ev_clr) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_r <= '0;
            irq <= 1'b0;
        end else begin
            ev_r <= ev_nxt;
            irq <= |(ev_nxt & mask_r);
        end
    end

    // Absolute error against threshold scaled by eight steps
    assign abs_err = phase_err_in[ERR_W-1] ? (~phase_err_in + 1'b1)
                                           : phase_err_in;
    assign thr_scaled = (ERR_W+THR_SCALE_SH+1)'(lock_ctl_r[15:0])
                        << THR_SCALE_SH;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_below_r <= 1'b0;
        end else begin
            // The most negative error has no positive twin; it never passes
            err_below_r <= ((ERR_W+THR_SCALE_SH+1)'(abs_err) < thr_scaled)
                           & ~(phase_err_in[ERR_W-1] & abs_err[ERR_W-1]);
        end
    end

    // Millisecond pacing for the lock interval
    dtl_ms_tick #(
        .DIV(MS_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(lk.ms_tick)
    );

    assign lk.run = loop_run;
    assign lk.err_below = err_below_r;
    // Odd timer values round each half interval down
    assign lk.half_ms = {1'b0, lock_ctl_r[31:LK_TIMER_LSB+1]};

    dtl_lock_det u_det (
        .pclk(pclk),
        .presetn(presetn),
        .lk(lk)
    );

    // Normal and locked share one code; the lock bit tells them apart
    assign st_code = (lk.state == LS_ACQ) ? ST_CODE_ACQUIRE : ST_CODE_NORMAL;

    // Fine timestamp bit order
    // Reversed order serves debug only; normal use keeps it off
    genvar gi;
    generate
        for (gi = 0; gi < 31; gi++) begin : g_rev
            assign fine_rev[gi] = fine_ts_in[30 - gi];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_ts_out <= 31'h00000000;
            sdm_d_r <= '0;
            sdm_err_out <= '0;
        end else begin
            fine_ts_out <= fb_corr_r[FC_REV_BIT] ? fine_rev : fine_ts_in;
            sdm_d_r <= sdm_err_in;
            // Only code one adds the extra stage; other codes pass directly
            if (fb_corr_r[FC_DLY_HI:FC_DLY_LO] == FC_DLY_ONE) begin
                sdm_err_out <= sdm_d_r;
            end else begin
                sdm_err_out <= sdm_err_in;
            end
        end
    end

    // Loop settings outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corr_mult_out <= 7'h00;
            phase_shift_out <= '0;
            fcw_out <= '0;
            fcw_load <= 1'b0;
            tdc_delay_out <= RST_TDC_DLY;
            filter_normal_sel <= 1'b0;
            lock_out <= 1'b0;
        end else begin
            corr_mult_out <= fb_corr_r[FC_MULT_HI:0];
            // Hitless switching owns the phase; manual offset is masked
            phase_shift_out <= hitless_en ? '0 : phs_act_r;
            fcw_out <= fcw_act_r;
            // Strobe leaves with the new word so the loop takes it whole
            fcw_load <= fcw_upd_r;
            tdc_delay_out <= tdc_dly_r;
            filter_normal_sel <= ctrl_r[CTRL_PROFILE_SW]
                                 & (lk.state != LS_ACQ);
            lock_out <= lk.locked;
        end
    end

endmodule // dtl_regs

// >>> dtl_regs_chk.sv
// Port-level assertions for the tuning and lock detect register bank
`timescale 1ns/1ps
module dtl_regs_chk
    import dtl_pkg::*;
(
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    // Loop side
    input wire logic hitless_en,
    input wire logic loop_run,
    input wire logic [PHS_W-1:0] phase_shift_out,
    input wire logic [FCW_W-1:0] fcw_out,
    input wire logic fcw_load,
    input wire logic [7:0] tdc_delay_out,
    input wire logic lock_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire wr_done = psel & penable & pready & pwrite;
    wire top_fcw = wr_done & pstrb[3] & (paddr == OFS_FCW);
    wire top_phs = wr_done & pstrb[3] & (paddr == OFS_PHASE);
    wire wr_tdc = wr_done & (paddr == OFS_TDC_DLY);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    property p_rdy_wait;
        s_setup ##1 s_access |-> !pready ##1 pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("late ready");

    property p_rdy_one;
        pready |=> !pready;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("long ready");

    property p_fcw_hold;
        $changed(fcw_out) |-> fcw_load;
    endproperty
    a_fcw_hold: assert property (p_fcw_hold)
        else $error("word moved without load");

    property p_fcw_load;
        fcw_load |-> $past(top_fcw, 2);
    endproperty
    a_fcw_load: assert property (p_fcw_load)
        else $error("load without top byte");

    property p_phs_hit;
        hitless_en [*2] |-> phase_shift_out == '0;
    endproperty
    a_phs_hit: assert property (p_phs_hit)
        else $error("shift used while hitless");

    property p_phs_atom;
        $changed(phase_shift_out) && !hitless_en && !$past(hitless_en)
            && !$past(hitless_en, 2) |-> $past(top_phs) || $past(top_phs, 2);
    endproperty
    a_phs_atom: assert property (p_phs_atom)
        else $error("shift moved without top byte");

    property p_tdc;
        $changed(tdc_delay_out) |-> $past(wr_tdc) || $past(wr_tdc, 2);
    endproperty
    a_tdc: assert property (p_tdc)
        else $error("delay moved without write");

    property p_lock_run;
        !loop_run [*3] |-> !lock_out;
    endproperty
    a_lock_run: assert property (p_lock_run) else $error("lock while idle");

    property p_lock_rise;
        $rose(lock_out) |-> $past(loop_run, 2) && $past(loop_run, 3);
    endproperty
    a_lock_rise: assert property (p_lock_rise)
        else $error("lock without run");
endmodule // dtl_regs_chk

bind dtl_regs dtl_regs_chk u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pstrb(pstrb), .pready(pready),
    .hitless_en(hitless_en), .loop_run(loop_run),
    .phase_shift_out(phase_shift_out), .fcw_out(fcw_out),
    .fcw_load(fcw_load), .tdc_delay_out(tdc_delay_out),
    .lock_out(lock_out)
);

// >>> test_dtl_regs.sv
// Self-checking bench for the tuning and lock detect register bank
`timescale 1ns/1ps
module test_dtl_regs;
    import dtl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, hitless_en, loop_run;
    logic pready, pslverr, fcw_load, filter_normal_sel, lock_out, irq;
    logic [7:0] paddr, tdc_delay_out;
    logic [31:0] pwdata, prdata, pv, fv;
    logic [3:0] pstrb;
    logic [30:0] fine_ts_in, fine_ts_out, f1, r;
    logic [15:0] sdm_err_in, sdm_err_out, s1, s2;
    logic [23:0] phase_err_in;
    logic [6:0] corr_mult_out, mult;
    logic [29:0] phase_shift_out;
    logic [28:0] fcw_out;
    logic [32:0] exp_q[$];
    logic [32:0] e_m;
    int n_fail, comparisons, t;

    // Short millisecond so qualification takes tens of cycles
    dtl_regs #(.MS_CYCLES(10)) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .fine_ts_in(fine_ts_in),
        .sdm_err_in(sdm_err_in), .phase_err_in(phase_err_in),
        .hitless_en(hitless_en), .loop_run(loop_run),
        .fine_ts_out(fine_ts_out), .sdm_err_out(sdm_err_out),
        .corr_mult_out(corr_mult_out), .phase_shift_out(phase_shift_out),
        .fcw_out(fcw_out), .fcw_load(fcw_load),
        .tdc_delay_out(tdc_delay_out),
        .filter_normal_sel(filter_normal_sel), .lock_out(lock_out),
        .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(string what, logic [31:0] seen, logic [31:0] ex);
        comparisons++;
        if (seen !== ex) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, ex, seen);
        end
    endtask

    task automatic finish_test;
        $display("Compared %0d, mismatched %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One transfer; the expected answer is queued for the monitor
    task automatic apb(logic [7:0] a, logic w, logic [31:0] d,
                       logic [3:0] s, logic [32:0] e);
        exp_q.push_back(e);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
        apb(a, 1'b1, d, s, 33'h0);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e);
        apb(a, 1'b0, 32'h0, 4'hF, {1'b0, e});
    endtask

    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e_m = exp_q.pop_front();
            chk("pslverr", 32'(pslverr), 32'(e_m[32]));
            if (!pwrite)
                chk("prdata", prdata, e_m[31:0]);
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        finish_test;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, hitless_en, loop_run} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        fine_ts_in = 31'h0;
        sdm_err_in = 16'h0;
        phase_err_in = 24'h0;
        void'($urandom(32'h5DF2));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("tdc_out", 32'(tdc_delay_out), 32'h1F);
        rd(OFS_FB_CORR, 32'h0);
        rd(OFS_PHASE, 32'h0);
        rd(OFS_FCW, 32'h0);
        rd(OFS_LOCK, 32'h00FF_0155);
        rd(OFS_TDC_DLY, 32'h1F);
        rd(OFS_MASK, 32'h0);
        apb(8'h40, 1'b0, 32'h0, 4'hF, 33'h1_0000_0000);
        apb(8'h40, 1'b1, 32'hFFFF_FFFF, 4'hF, 33'h1_0000_0000);
        wr(OFS_TDC_DLY, 32'hA5, 4'h1);
        settle;
        chk("tdc_out", 32'(tdc_delay_out), 32'hA5);
        $display("test reset_and_map done");

        for (int m = 0; m < 8; m++) begin
            mult = 7'($urandom);
            wr(OFS_FB_CORR, {22'h0, 3'(m), mult}, 4'h3);
            for (int i = 0; i < 6; i++) begin
                @(posedge pclk);
                fine_ts_in <= 31'($urandom);
                sdm_err_in <= 16'($urandom);
                #1;
                r = {<<{f1}};
                if (i > 1) begin
                    chk("fine_ts", 32'(fine_ts_out),
                        32'(m[2] ? r : f1));
                    chk("sdm", 32'(sdm_err_out),
                        32'(m[1:0] == 1 ? s2 : s1));
                end
                s2 = s1;
                s1 = sdm_err_in;
                f1 = fine_ts_in;
            end
            chk("mult", 32'(corr_mult_out), 32'(mult));
        end
        $display("test feedback_correction done");

        pv = $urandom & 32'h3FFF_FFFF;
        wr(OFS_PHASE, pv, 4'h7);
        settle;
        chk("phase", 32'(phase_shift_out), 32'h0);
        rd(OFS_PHASE, {8'h0, pv[23:0]});
        wr(OFS_PHASE, pv, 4'h8);
        settle;
        chk("phase", 32'(phase_shift_out), pv);
        @(posedge pclk) hitless_en <= 1'b1;
        settle;
        chk("phase", 32'(phase_shift_out), 32'h0);
        @(posedge pclk) hitless_en <= 1'b0;
        settle;
        chk("phase", 32'(phase_shift_out), pv);
        fv = 32'h1000_0000 | ($urandom & 32'h0FFF_FFFF);
        wr(OFS_FCW, fv, 4'h7);
        settle;
        chk("fcw", 32'(fcw_out), 32'h0);
        wr(OFS_FCW, fv, 4'h8);
        settle;
        chk("fcw", 32'(fcw_out), 32'(fv[28:0]));
        wr(OFS_FCW, 32'h0500_0000, 4'h8);
        settle;
        chk("fcw", 32'(fcw_out), {8'h05, fv[23:0]});
        $display("test atomic_words done");

        // Half interval of two ticks, threshold 128 steps
        wr(OFS_LOCK, 32'h0004_0010, 4'hF);
        wr(OFS_CTRL, 32'h1, 4'h1);
        @(posedge pclk) loop_run <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            repeat (7) @(posedge pclk);
            phase_err_in <= i[0] ? 24'd128 : -24'sd128;
            @(posedge pclk) phase_err_in <= 24'd127;
        end
        #1;
        chk("normal_sel", 32'(filter_normal_sel), 32'h0);
        t = 0;
        while (filter_normal_sel !== 1'b1 && t < 60) begin
            @(posedge pclk);
            t++;
        end
        chk("to_normal", 32'(t >= 11 && t <= 24), 32'h1);
        chk("lock_early", 32'(lock_out), 32'h0);
        t = 0;
        while (lock_out !== 1'b1 && t < 60) begin
            @(posedge pclk);
            t++;
        end
        chk("to_lock", 32'(t >= 18 && t <= 22), 32'h1);
        rd(OFS_STATUS, 32'h11);
        @(posedge pclk) phase_err_in <= 24'h80_0000;
        settle;
        chk("lock", 32'(lock_out), 32'h0);
        chk("normal_sel", 32'(filter_normal_sel), 32'h0);
        chk("irq", 32'(irq), 32'h0);
        wr(OFS_MASK, 32'h1, 4'h1);
        settle;
        chk("irq", 32'(irq), 32'h1);
        rd(OFS_STATUS, 32'h40);
        wr(OFS_EVENT, 32'h1, 4'h1);
        settle;
        chk("irq", 32'(irq), 32'h0);
        rd(OFS_EVENT, 32'h6);
        rd(OFS_EVENT, 32'h0);
        @(posedge pclk) loop_run <= 1'b0;
        settle;
        $display("test lock_and_events done");
        finish_test;
    end
endmodule // test_dtl_regs
